//--- src/hrc_top.sv
// Purpose: hub reset and configuration sequencer with serial config slave
// Assumes: presetn is the hardware reset; serial pins are asynchronous to pclk
// Notes: config store is 256 bytes; apb gives software a view of it
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
module hrc_top
   import hrc_pkg::*;
#(
   parameter int NPORT = 4,
   parameter int REC_CYC = REC_CYC_DEF,
   parameter int EE_CYC = EE_CYC_DEF,
   parameter int TMO_CYC = TMO_CYC_DEF
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic smb_clk_in,
   input wire logic smb_data_in,
   output logic smb_data_out,
   output logic smb_data_oe,
   input wire logic [1:0] cfg_sel,
   input wire logic [NPORT-1:0] strap_opt,
   output logic usb_attach,
   output logic hub_ready,
   output logic phy_en,
   output logic osc_run,
   output logic pll_run,
   output logic [NPORT-1:0] port_power_en,
   output logic [NPORT-1:0] charge_port_en
);
   generate
      if (NPORT < 1 || NPORT > 8 || REC_CYC < 1 || EE_CYC < 1 || TMO_CYC < 1 ||
          TMO_CYC > TMO_MAX_CYC || REC_CYC >= 2**CNT_W || EE_CYC >= 2**CNT_W)
      begin : g_bad
         $error("hrc_top: parameter out of range");
      end
   endgenerate

   function automatic logic valid_reg(input logic [7:0] a);
      valid_reg = (a <= REG_LAST) || (a == CTL_IDX);
   endfunction

   function automatic logic [CNT_W-1:0] lim(input int n);
      lim = CNT_W'(n - 1);
   endfunction

   // ***********************
   // synchronisers
   // ***********************
   logic scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
   logic [1:0] cfg_s1_q, cfg_s2_q;
   logic [NPORT-1:0] opt_s1_q, opt_s2_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         scl_s1_q <= 1'b1;
         scl_s2_q <= 1'b1;
         scl_s3_q <= 1'b1;
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
         sda_s3_q <= 1'b1;
         cfg_s1_q <= 2'h0;
         cfg_s2_q <= 2'h0;
         opt_s1_q <= '0;
         opt_s2_q <= '0;
      end
      else
      begin
         scl_s1_q <= smb_clk_in;
         scl_s2_q <= scl_s1_q;
         scl_s3_q <= scl_s2_q;
         sda_s1_q <= smb_data_in;
         sda_s2_q <= sda_s1_q;
         sda_s3_q <= sda_s2_q;
         cfg_s1_q <= cfg_sel;
         cfg_s2_q <= cfg_s1_q;
         opt_s1_q <= strap_opt;
         opt_s2_q <= opt_s1_q;
      end
   end

   wire scl_rise = scl_s2_q & ~scl_s3_q;
   wire scl_fall = ~scl_s2_q & scl_s3_q;
   wire start_w = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;
   wire stop_w = scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q;

   // ***********************
   // reset sequencer
   // ***********************
   hrc_seq_t seq_q;
   hrc_cfg_t mode_q;
   logic [CNT_W-1:0] cnt_q;
   logic usb_attach_q, hub_ready_q, phy_en_q, osc_run_q, pll_run_q, ctrl_q;
   logic [7:0] mem_q [0:255];
   wire attach_req = mem_q[CTL_IDX][ATTACH_BIT] | ctrl_q;
   wire strap_ld = (seq_q == SQ_LATCH) && (cnt_q == lim(SYNC_CYC + 1)) && (hrc_cfg_t'(cfg_s2_q) == CFG_STRAP);

   // everything here is async-cleared, so reset kills clocks, phy and any sequence in flight
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         seq_q <= SQ_LATCH;
         mode_q <= CFG_STRAP;
         cnt_q <= '0;
         usb_attach_q <= 1'b0;
         hub_ready_q <= 1'b0;
         phy_en_q <= 1'b0;
         osc_run_q <= 1'b0;
         pll_run_q <= 1'b0;
      end
      else
      begin
         osc_run_q <= 1'b1;
         pll_run_q <= 1'b1;
         cnt_q <= cnt_q + 1'b1;
         case (seq_q)
            SQ_LATCH:
               // straps need the synchroniser filled before they are trusted
               if (cnt_q == lim(SYNC_CYC + 1))
               begin
                  mode_q <= hrc_cfg_t'(cfg_s2_q);
                  seq_q <= (hrc_cfg_t'(cfg_s2_q) == CFG_STRAP) ? SQ_STRAP : SQ_REC;
               end
            SQ_STRAP:
            begin
               if (cnt_q == lim(INACT_CYC))
               begin
                  hub_ready_q <= 1'b1;
                  phy_en_q <= 1'b1;
               end
               if (cnt_q == lim(ATT_CYC))
               begin
                  usb_attach_q <= 1'b1;
                  seq_q <= SQ_ON;
               end
            end
            SQ_REC:
               if (cnt_q == lim(REC_CYC + SYNC_CYC + 2))
               begin
                  hub_ready_q <= 1'b1;
                  phy_en_q <= 1'b1;
                  cnt_q <= '0;
                  seq_q <= (mode_q == CFG_SMB) ? SQ_SMB : SQ_EE;
               end
            SQ_EE:
               // no eeprom master here: the read window is modelled by its typical time
               if (cnt_q == lim(EE_CYC))
               begin
                  usb_attach_q <= 1'b1;
                  seq_q <= SQ_ON;
               end
            SQ_SMB:
            begin
               cnt_q <= '0;
               if (attach_req)
               begin
                  usb_attach_q <= 1'b1;
                  seq_q <= SQ_ON;
               end
            end
            SQ_ON:
               cnt_q <= '0;
            default:
               seq_q <= SQ_LATCH;
         endcase
      end
   end

   // ***********************
   // serial config slave
   // ***********************
   hrc_smb_t st_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q, tx_q, ptr_q, cnt8_q, wa_q, wd_q;
   logic oe_q, nack_q, cmd_ok_q, we_q;
   logic [CNT_W-1:0] tmo_q;

   wire smb_en = (mode_q == CFG_SMB) && hub_ready_q;
   wire tmo_hit = (tmo_q == lim(TMO_CYC));
   wire tx_st = (st_q == ST_RCNT) || (st_q == ST_RDATA);
   wire addr_hit = (sh_q[7:1] == SMB_ADDR); // general call never matches
   wire blk_ok = (sh_q != 8'h00) && (sh_q <= MAX_BLK);
   wire prot = usb_attach_q && (ptr_q != CTL_IDX);
   wire [7:0] txb = (st_q == ST_RCNT) ? RD_LEN : mem_q[ptr_q];
   wire rx_ack = (st_q == ST_ADDR) ? (addr_hit && (!sh_q[0] || cmd_ok_q)) :
                 (st_q == ST_CMD) ? valid_reg(sh_q) :
                 (st_q == ST_CNT) ? blk_ok :
                 (st_q == ST_WDATA) ? (cnt8_q != 8'h00) : 1'b0;
   wire hrc_smb_t rx_nxt = !rx_ack ? ST_IGN :
                           (st_q == ST_ADDR) ? (sh_q[0] ? ST_RCNT : ST_CMD) :
                           (st_q == ST_CMD) ? ST_CNT : ST_WDATA;

   // clock-low watchdog only runs inside a transfer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tmo_q <= '0;
      else if (!smb_en || st_q == ST_IDLE || scl_s2_q || tmo_hit)
         tmo_q <= '0;
      else
         tmo_q <= tmo_q + 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q <= ST_IDLE;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         tx_q <= 8'h00;
         ptr_q <= 8'h00;
         cnt8_q <= 8'h00;
         oe_q <= 1'b0;
         nack_q <= 1'b0;
         cmd_ok_q <= 1'b0;
         we_q <= 1'b0;
         wa_q <= 8'h00;
         wd_q <= 8'h00;
      end
      else
      begin
         we_q <= 1'b0;
         if (!smb_en || tmo_hit || stop_w)
         begin
            st_q <= ST_IDLE;
            oe_q <= 1'b0;
            bit_q <= 4'h0;
            cmd_ok_q <= 1'b0;
         end
         else if (start_w)
         begin
            st_q <= ST_ADDR;
            bit_q <= 4'h0;
            oe_q <= 1'b0;
         end
         else if (st_q != ST_IDLE && scl_rise)
         begin
            if (bit_q < 4'h8)
            begin
               sh_q <= {sh_q[6:0], sda_s2_q};
               bit_q <= bit_q + 4'h1;
            end
            else if (bit_q == 4'h9 && tx_st)
               nack_q <= sda_s2_q;
         end
         else if (st_q != ST_IDLE && scl_fall)
         begin
            if (bit_q == 4'h8)
            begin
               bit_q <= 4'h9;
               if (tx_st)
               begin
                  oe_q <= 1'b0;
                  if (st_q == ST_RCNT)
                     st_q <= ST_RDATA;
                  else
                  begin
                     ptr_q <= ptr_q + 8'h01;
                     cnt8_q <= cnt8_q - 8'h01;
                  end
               end
               else
               begin
                  oe_q <= rx_ack;
                  st_q <= rx_nxt;
                  if (st_q == ST_CMD)
                  begin
                     ptr_q <= sh_q;
                     cmd_ok_q <= rx_ack;
                  end
                  if (st_q == ST_CNT)
                     cnt8_q <= sh_q;
                  if (st_q == ST_ADDR && rx_nxt == ST_RCNT)
                  begin
                     cnt8_q <= RD_LEN;
                     nack_q <= 1'b0;
                  end
                  if (st_q == ST_WDATA && rx_ack)
                  begin
                     // only a block write reaches here, so other protocols never store
                     we_q <= !prot;
                     wa_q <= ptr_q;
                     wd_q <= sh_q;
                     ptr_q <= ptr_q + 8'h01;
                     cnt8_q <= cnt8_q - 8'h01;
                  end
               end
            end
            else if (bit_q == 4'h9)
            begin
               bit_q <= 4'h0;
               oe_q <= 1'b0;
               if (tx_st)
               begin
                  if (nack_q || (st_q == ST_RDATA && cnt8_q == 8'h00))
                     st_q <= ST_IGN;
                  else
                  begin
                     oe_q <= ~txb[7];
                     tx_q <= {txb[6:0], 1'b0};
                  end
               end
            end
            else if (tx_st && bit_q != 4'h0)
            begin
               oe_q <= ~tx_q[7];
               tx_q <= {tx_q[6:0], 1'b0};
            end
         end
      end
   end

   // ***********************
   // config store
   // ***********************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < 256; i++)
            mem_q[i] <= MEM_RST;
      end
      else if (we_q)
         mem_q[wa_q] <= wd_q;
      else if (strap_ld)
         mem_q[CHG_IDX] <= 8'(opt_s2_q);
   end

   logic [NPORT-1:0] pwr_q, chg_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pwr_q <= '0;
         chg_q <= '0;
      end
      else
      begin
         chg_q <= mem_q[CHG_IDX][NPORT-1:0];
         pwr_q <= usb_attach_q ? {NPORT{1'b1}} : mem_q[CHG_IDX][NPORT-1:0];
      end
   end

   // ***********************
   // apb slave
   // ***********************
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q;
   logic [7:0] idx_q;
   wire apb_setup = psel & ~penable;
   wire apb_wr = psel & penable & pready_q & pwrite;
   wire hit_st = (paddr == A_STATUS);
   wire hit_ct = (paddr == A_CTRL);
   wire hit_ix = (paddr == A_IDX);
   wire hit_dt = (paddr == A_DATA);
   wire hit_any = hit_st | hit_ct | hit_ix | hit_dt;
   wire [31:0] stat_w = {20'h0, cmd_ok_q, st_q, 1'b0, mode_q, seq_q, hub_ready_q, usb_attach_q};
   wire [31:0] rd_w = hit_st ? stat_w : hit_ct ? {31'h0, ctrl_q} :
                      hit_ix ? {24'h0, idx_q} : hit_dt ? {24'h0, mem_q[idx_q]} : 32'h0;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_q <= 32'h0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         ctrl_q <= 1'b0;
         idx_q <= 8'h00;
      end
      else
      begin
         pready_q <= apb_setup;
         if (apb_setup)
         begin
            prdata_q <= rd_w;
            pslverr_q <= ~hit_any;
         end
         if (apb_wr && hit_ct)
            ctrl_q <= pwdata[0];
         if (apb_wr && hit_ix)
            idx_q <= pwdata[7:0];
      end
   end

   // clock pin is input only and no alert pin exists
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign smb_data_out = 1'b0;
   assign smb_data_oe = oe_q;
   assign usb_attach = usb_attach_q;
   assign hub_ready = hub_ready_q;
   assign phy_en = phy_en_q;
   assign osc_run = osc_run_q;
   assign pll_run = pll_run_q;
   assign port_power_en = pwr_q;
   assign charge_port_en = chg_q;

   // ***********************
   // checks
   // ***********************
   property p_tmo;
      @(posedge pclk) disable iff (!presetn) tmo_hit |=> (st_q == ST_IDLE) && !oe_q;
   endproperty
   a_tmo: assert property (p_tmo) else $error("timeout did not idle slave");
   property p_tmo_rst;
      @(posedge pclk) disable iff (!presetn) scl_rise |=> tmo_q == '0;
   endproperty
   a_tmo_rst: assert property (p_tmo_rst) else $error("clock rise did not restart timer");
   property p_addr;
      @(posedge pclk) disable iff (!presetn)
         (scl_fall && bit_q == 4'h8 && st_q == ST_ADDR && !addr_hit && !start_w && !stop_w && !tmo_hit)
         |=> !oe_q && st_q == ST_IGN;
   endproperty
   a_addr: assert property (p_addr) else $error("foreign address acknowledged");
   property p_reg;
      @(posedge pclk) disable iff (!presetn)
         (scl_fall && bit_q == 4'h8 && st_q == ST_CMD && !valid_reg(sh_q) && !stop_w && !tmo_hit)
         |=> !oe_q ##1 !cmd_ok_q;
   endproperty
   a_reg: assert property (p_reg) else $error("undefined register answered");
   property p_cnt;
      @(posedge pclk) disable iff (!presetn)
         (scl_fall && bit_q == 4'h8 && st_q == ST_CNT && !blk_ok) |=> !oe_q && !we_q;
   endproperty
   a_cnt: assert property (p_cnt) else $error("bad byte count acknowledged");
   property p_prot;
      @(posedge pclk) disable iff (!presetn) we_q |-> (!$past(usb_attach_q) || wa_q == CTL_IDX);
   endproperty
   a_prot: assert property (p_prot) else $error("write into protected range");
   property p_stop;
      @(posedge pclk) disable iff (!presetn) stop_w |=> st_q == ST_IDLE && !oe_q;
   endproperty
   a_stop: assert property (p_stop) else $error("stop did not idle slave");
   property p_strap;
      @(posedge pclk) disable iff (!presetn)
         (seq_q == SQ_STRAP && cnt_q == lim(ATT_CYC)) |=> usb_attach_q && hub_ready_q && phy_en_q;
   endproperty
   a_strap: assert property (p_strap) else $error("strap attach late");
   property p_rec;
      @(posedge pclk) disable iff (!presetn)
         (seq_q == SQ_REC) |-> !hub_ready_q && !usb_attach_q;
   endproperty
   a_rec: assert property (p_rec) else $error("ready during recovery");
   property p_wait;
      @(posedge pclk) disable iff (!presetn) (seq_q == SQ_SMB && !attach_req) |=> !usb_attach_q;
   endproperty
   a_wait: assert property (p_wait) else $error("attach before config load");
endmodule
`default_nettype wire

//--- src/hrc_pkg.sv
// Purpose: constants for the hub reset/config sequencer and its serial config slave
// Assumes: pclk at 10 MHz
// Notes: times are kept in their printed units, cycle counts derive from CLK_KHZ
package hrc_pkg;
   localparam int CLK_KHZ = 10000;
   localparam int CNT_W = 20;
   // ***********************
   // timing
   // ***********************
   localparam int REC_US = 500;
   localparam int REC_CYC_DEF = REC_US * CLK_KHZ / 1000;
   localparam int INACT_US = 2;
   localparam int INACT_CYC = INACT_US * CLK_KHZ / 1000;
   localparam int ATT_US = 3;
   localparam int ATT_CYC = ATT_US * CLK_KHZ / 1000;
   localparam int EE_MS = 40;
   localparam int EE_CYC_DEF = EE_MS * CLK_KHZ;
   localparam int TMO_MIN_MS = 25;
   localparam int TMO_CYC_DEF = TMO_MIN_MS * CLK_KHZ;
   localparam int TMO_MAX_MS = 35;
   localparam int TMO_MAX_CYC = TMO_MAX_MS * CLK_KHZ;
   localparam int SYNC_CYC = 2;
   // ***********************
   // serial slave
   // ***********************
   localparam logic [6:0] SMB_ADDR = 7'h2c;
   localparam logic [7:0] MAX_BLK = 8'h20;
   localparam logic [7:0] RD_LEN = 8'h20;
   localparam logic [7:0] REG_LAST = 8'h3f;
   localparam logic [7:0] CTL_IDX = 8'hff;
   localparam logic [7:0] CHG_IDX = 8'h00;
   localparam int ATTACH_BIT = 0;
   localparam logic [7:0] MEM_RST = 8'h00;
   // ***********************
   // apb map
   // ***********************
   localparam logic [11:0] A_STATUS = 12'h000;
   localparam logic [11:0] A_CTRL = 12'h004;
   localparam logic [11:0] A_IDX = 12'h008;
   localparam logic [11:0] A_DATA = 12'h00c;
   typedef enum logic [1:0] {CFG_STRAP = 2'b00, CFG_EE1 = 2'b01, CFG_EE2 = 2'b10, CFG_SMB = 2'b11} hrc_cfg_t;
   typedef enum logic [2:0] {SQ_LATCH = 3'b000, SQ_REC = 3'b001, SQ_STRAP = 3'b010, SQ_EE = 3'b011,
      SQ_SMB = 3'b100, SQ_ON = 3'b101} hrc_seq_t;
   typedef enum logic [2:0] {ST_IDLE = 3'b000, ST_ADDR = 3'b001, ST_CMD = 3'b010, ST_CNT = 3'b011,
      ST_WDATA = 3'b100, ST_RCNT = 3'b101, ST_RDATA = 3'b110, ST_IGN = 3'b111} hrc_smb_t;
endpackage

//--- verification/hrc_smb_host.sv
// Purpose: serial config master model facing the slave port
// Assumes: 800 ns link clock, pull-ups on clock and data
// Notes: clock stands high between frames; data released means high
`timescale 1ns/10ps
`default_nettype none
module hrc_smb_host
(
   input wire logic pclk,
   input wire logic sda_in,
   output logic scl,
   output logic sda_h
);
   // ***************
   // bus primitives
   // ***************
   initial
   begin
      scl = 1'b1;
      sda_h = 1'b1;
   end
   // data moves one pclk after the fall, never while clock is high
   task automatic tick(input logic b, output logic s);
      @(posedge pclk) sda_h <= b;
      repeat (3) @(posedge pclk);
      scl <= 1'b1;
      repeat (4) @(posedge pclk);
      s = sda_in;
      scl <= 1'b0;
   endtask
   task automatic start();
      @(posedge pclk) sda_h <= 1'b1;
      repeat (3) @(posedge pclk);
      scl <= 1'b1;
      repeat (4) @(posedge pclk);
      sda_h <= 1'b0;
      repeat (4) @(posedge pclk);
      scl <= 1'b0;
   endtask
   task automatic stop();
      @(posedge pclk) sda_h <= 1'b0;
      repeat (3) @(posedge pclk);
      scl <= 1'b1;
      repeat (4) @(posedge pclk);
      sda_h <= 1'b1;
      repeat (4) @(posedge pclk);
   endtask
   task automatic wbyte(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         tick(v[i], s);
      tick(1'b1, s);
      ack = ~s;
   endtask
   task automatic rbyte(input logic nack, output logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         tick(1'b1, s);
         v[i] = s;
      end
      tick(nack, s);
   endtask
endmodule
`default_nettype wire

//--- verification/hub_reset_config_smbus_slave_tb.sv
// Purpose: self-checking bench for the reset sequencer and config slave
// Assumes: counts shortened through the top parameters
// Notes: config bytes are read back over apb
`timescale 1ns/10ps
`default_nettype none
module hub_reset_config_smbus_slave_tb;
   import hrc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, smb_data_out, smb_data_oe, scl, sda_h;
   logic usb_attach, hub_ready, phy_en, osc_run, pll_run;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [1:0] cfg_sel;
   logic [3:0] strap_opt, port_power_en, charge_port_en;
   int n_mismatch, total_checks;
   // open drain with pull-up: released data reads high
   wire logic sda = sda_h & ~(smb_data_oe & ~smb_data_out);
   hrc_top #(.NPORT(4), .REC_CYC(50), .EE_CYC(200), .TMO_CYC(300)) i_dut (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .smb_clk_in(scl), .smb_data_in(sda), .smb_data_out,
      .smb_data_oe, .cfg_sel, .strap_opt, .usb_attach, .hub_ready, .phy_en, .osc_run, .pll_run, .port_power_en,
      .charge_port_en);
   hrc_smb_host i_host (.pclk, .sda_in(sda), .scl, .sda_h);
   // ***************
   // shared tasks
   // ***************
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
      output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a missing answer
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdcfg(input logic [7:0] ix, output logic [7:0] v);
      logic [31:0] q;
      logic e;
      apb(1'b1, A_IDX, {24'h0, ix}, q, e);
      apb(1'b0, A_DATA, 32'h0, q, e);
      v = q[7:0];
   endtask
   task automatic do_reset(input logic [1:0] m);
      @(posedge pclk);
      presetn <= 1'b0;
      cfg_sel <= m;
      repeat (10) @(posedge pclk);
      chk({usb_attach, hub_ready, phy_en, osc_run, pll_run, smb_data_oe, port_power_en, charge_port_en}, 0);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      chk({osc_run, pll_run}, 2'b11);
   endtask
   task automatic bw(input logic [6:0] ad, input logic [7:0] cmd, input logic [7:0] cnt, input logic [7:0] d,
      output logic [3:0] ak);
      i_host.start();
      i_host.wbyte({ad, 1'b0}, ak[3]);
      i_host.wbyte(cmd, ak[2]);
      i_host.wbyte(cnt, ak[1]);
      i_host.wbyte(d, ak[0]);
      i_host.stop();
   endtask
   // ***************
   // scenarios
   // ***************
   task automatic t_strap();
      logic [7:0] v;
      strap_opt <= 4'b1010;
      do_reset(CFG_STRAP);
      repeat (13) @(posedge pclk);
      chk({hub_ready, phy_en}, 2'b00);
      repeat (10) @(posedge pclk);
      chk({hub_ready, phy_en, usb_attach}, 3'b110);
      repeat (10) @(posedge pclk);
      chk({usb_attach, port_power_en, charge_port_en}, 9'h1fa);
      // no bus reset ever follows attach here
      rdcfg(8'h01, v);
      chk(v, 8'h00);
   endtask
   task automatic t_ee(input logic [1:0] m);
      do_reset(m);
      repeat (40) @(posedge pclk);
      chk(hub_ready, 1'b0);
      repeat (20) @(posedge pclk);
      chk(hub_ready, 1'b1);
      repeat (150) @(posedge pclk);
      chk(usb_attach, 1'b0);
      repeat (60) @(posedge pclk);
      chk(usb_attach, 1'b1);
   endtask
   task automatic t_smb();
      logic [3:0] ak;
      logic [7:0] v;
      logic [31:0] q;
      logic e;
      do_reset(CFG_SMB);
      repeat (70) @(posedge pclk);
      bw(SMB_ADDR, 8'h01, 8'h01, 8'hc4, ak);
      rdcfg(8'h01, v);
      chk({ak, v}, 12'hfc4);
      bw(7'h00, 8'h02, 8'h01, 8'h55, ak);
      chk(ak[3], 1'b0);
      bw(7'h2d, 8'h02, 8'h01, 8'h55, ak);
      chk(ak[3], 1'b0);
      bw(SMB_ADDR, 8'h40, 8'h01, 8'h55, ak);
      chk(ak[3:2], 2'b10);
      bw(SMB_ADDR, 8'h02, 8'h00, 8'h55, ak);
      chk(ak[3:1], 3'b110);
      bw(SMB_ADDR, 8'h02, 8'h21, 8'h55, ak);
      chk(ak[3:1], 3'b110);
      rdcfg(8'h02, v);
      chk(v, 8'h00);
      i_host.start();
      i_host.wbyte({SMB_ADDR, 1'b0}, ak[3]);
      i_host.wbyte(8'h01, ak[2]);
      i_host.start();
      i_host.wbyte({SMB_ADDR, 1'b1}, ak[1]);
      i_host.rbyte(1'b0, v);
      chk({ak[3:1], v}, {3'b111, RD_LEN});
      i_host.rbyte(1'b1, v);
      chk(v, 8'hc4);
      i_host.stop();
      i_host.start();
      i_host.wbyte({SMB_ADDR, 1'b0}, ak[3]);
      i_host.start();
      i_host.stop();
      apb(1'b0, A_STATUS, 32'h0, q, e);
      chk(q[10:8], ST_IDLE);
      bw(SMB_ADDR, 8'h03, 8'h01, 8'h77, ak);
      rdcfg(8'h03, v);
      chk({ak, v}, 12'hf77);
      // clock held low through the address ack until the slave gives up
      i_host.start();
      v = {SMB_ADDR, 1'b0};
      for (int i = 7; i >= 0; i--)
         i_host.tick(v[i], e);
      repeat (6) @(posedge pclk);
      chk({smb_data_oe, smb_data_out}, 2'b10);
      // still held just short of the limit, released just after it
      repeat (280) @(posedge pclk);
      chk(smb_data_oe, 1'b1);
      repeat (40) @(posedge pclk);
      chk(smb_data_oe, 1'b0);
      i_host.stop();
      bw(SMB_ADDR, 8'h04, 8'h01, 8'h3c, ak);
      chk({ak, usb_attach}, 5'h1e);
      apb(1'b1, A_CTRL, 32'h1, q, e);
      repeat (4) @(posedge pclk);
      chk({usb_attach, port_power_en}, 5'h1f);
      bw(SMB_ADDR, 8'h01, 8'h01, 8'h11, ak);
      rdcfg(8'h01, v);
      chk({ak, v}, 12'hfc4);
      apb(1'b0, A_STATUS, 32'h0, q, e);
      chk({e, q[6:5], q[0]}, 4'b0111);
      apb(1'b0, 12'h010, 32'h0, q, e);
      chk({e, q}, {1'b1, 32'h0});
      i_host.start();
      i_host.wbyte({SMB_ADDR, 1'b0}, ak[3]);
      do_reset(CFG_STRAP);
      i_host.stop();
      rdcfg(8'h01, v);
      chk(v, 8'h00);
   endtask
   initial
   begin
      repeat (40000) @(posedge pclk);
      n_mismatch++;
      conclude();
   end
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata, cfg_sel, strap_opt} = '0;
      n_mismatch = 0;
      total_checks = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_strap();
      t_ee(CFG_EE1);
      t_ee(CFG_EE2);
      t_smb();
      conclude();
   end
endmodule
`default_nettype wire
